/* inc/fmsep_pkg.sv */
package fmsep_pkg;
	// Board clock and separator clock rates
	localparam int unsigned CLK_HZ        = 100_000_000;
	localparam int unsigned SEP_HZ        = 2_000_000;
	localparam int unsigned SEP_DIV       = CLK_HZ / SEP_HZ;
	localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
	// One-shot periods in milliseconds
	localparam int unsigned DSEL_TIME_MS  = 4500;
	localparam int unsigned HSET_TIME_MS  = 75;
	localparam int unsigned DSEL_CYC      = DSEL_TIME_MS * CYC_PER_MS;
	localparam int unsigned HSET_CYC      = HSET_TIME_MS * CYC_PER_MS;
	// Separator counter
	localparam logic [2:0]  SEP_LOAD_LOW  = 3'h5;
	localparam logic [3:0]  SEP_CNT_RST   = 4'h0;
	localparam int unsigned SEP_MSB       = 3;
	// Status byte layout
	localparam int unsigned ST_NOT_READY  = 7;
	localparam int unsigned ST_COND_LSB   = 2;
	localparam int unsigned ST_DRQ        = 1;
	localparam int unsigned ST_BUSY       = 0;
	localparam logic [7:0]  STATUS_RST    = 8'h00;
	// Drive control byte layout
	localparam int unsigned CTL_MOTOR     = 4;
	localparam int unsigned CTL_STRAP_LOW = 6;
	localparam logic [3:0]  CTL_SEL_RST   = 4'h0;
	// Buffer word: bit 1 data pulse, bit 0 clock pulse
	localparam int unsigned W_CLOCK       = 0;
	localparam int unsigned W_DATA        = 1;
	typedef logic [1:0] fmsep_word_t;
endpackage : fmsep_pkg

/* inc/fmsep_buf_if.sv */
`timescale 1ns/1ns
interface fmsep_buf_if;
	import fmsep_pkg::*;
	logic        valid;
	logic        ready;
	fmsep_word_t data;
	modport prod (output valid, output data, input ready);
	modport cons (input valid, input data, output ready);
endinterface : fmsep_buf_if

/* hdl/fmsep_buf.sv */
`timescale 1ns/1ns
module fmsep_buf
	import fmsep_pkg::*;
(
	// Clock and reset
	input wire logic  clk,
	input wire logic  rst,
	// Fill and drain sides
	fmsep_buf_if.cons in_if,
	fmsep_buf_if.prod out_if
);
	fmsep_word_t mem_reg [2];
	logic        wr_ptr_reg;
	logic        rd_ptr_reg;
	logic [1:0]  count_reg;
	logic        push;
	logic        pop;

	assign in_if.ready  = (count_reg != 2'h2);
	assign out_if.valid = (count_reg != 2'h0);
	assign out_if.data  = mem_reg[rd_ptr_reg];
	assign push         = in_if.valid && in_if.ready;
	assign pop          = out_if.valid && out_if.ready;

	always_ff @(posedge clk) begin
		if (rst) begin
			mem_reg[0] <= '0;
			mem_reg[1] <= '0;
		end else if (push) begin
			mem_reg[wr_ptr_reg] <= in_if.data;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wr_ptr_reg <= 1'b0;
			rd_ptr_reg <= 1'b0;
			count_reg  <= 2'h0;
		end else begin
			if (push)
				wr_ptr_reg <= ~wr_ptr_reg;
			if (pop)
				rd_ptr_reg <= ~rd_ptr_reg;
			count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
		end
	end

	a_buf_no_overrun: assert property (@(posedge clk) disable iff (rst)
		count_reg == 2'h2 |-> !in_if.ready)
		else $error("buffer accepts while full");
endmodule : fmsep_buf

/* hdl/fmsep_top.sv */
`timescale 1ns/1ns
module fmsep_top
	import fmsep_pkg::*;
#(
	parameter int unsigned DSEL_CYCLES = DSEL_CYC,
	parameter int unsigned HSET_CYCLES = HSET_CYC
) (
	// Clock and reset
	input  wire logic       CLK,
	input  wire logic       RST,
	// Drive pins
	input  wire logic       RAW_READ_N,
	input  wire logic       DRIVE_READY_N,
	input  wire logic       STRAP_JUMPER,
	output logic [3:0]      DRIVE_SELECT,
	output logic            MOTOR_ON,
	output logic            STRAP_SENSE_POINT,
	// Drive control port
	input  wire logic       CTRL_WR,
	input  wire logic [7:0] CTRL_DATA,
	// Formatter status byte
	input  wire logic       STATUS_RD,
	input  wire logic       BUSY,
	input  wire logic       DATA_REQUEST_FLAG,
	input  wire logic [4:0] STATUS_COND,
	output logic [7:0]      STATUS_DATA,
	output logic            FMT_READY,
	// Head load and transfer gating
	input  wire logic       HEAD_LOAD_REQUEST,
	input  wire logic       XFER_REQ,
	output logic            HEAD_SETTLE_INPUT,
	output logic            XFER_GO,
	// Separated pulses
	input  wire logic       SEP_READY,
	output logic            SEP_VALID,
	output logic            SEP_CLOCK_PULSE,
	output logic            SEP_DATA_PULSE
);
	logic [1:0]  raw_sync_reg;
	logic [1:0]  rdy_sync_reg;
	logic [1:0]  strap_sync_reg;
	logic        raw_prev_reg;
	logic        nrz_reg;
	logic        nrz_tick_reg;
	logic [5:0]  div_reg;
	logic        tick;
	logic        sep_pulse;
	logic [3:0]  cnt_reg;
	logic [3:0]  cnt_next;
	logic        pend_reg;
	fmsep_word_t pend_word_reg;
	logic [31:0] dsel_cnt_reg;
	logic        dsel_run;
	logic [31:0] hset_cnt_reg;
	logic        hld_prev_reg;
	logic        hld_rise;
	logic [3:0]  sel_reg;
	logic        strap_low_reg;
	logic        motor_reg;
	logic        drive_ok;

	fmsep_buf_if fill_if ();
	fmsep_buf_if drain_if ();

	function automatic logic [31:0] oneshot_next(input logic fire, input logic [31:0] cur, input int unsigned per);
		if (fire)
			return per;
		return (cur != 32'h0000_0000) ? cur - 32'h0000_0001 : cur;
	endfunction : oneshot_next

	// Pin synchronizers
	always_ff @(posedge CLK) begin
		if (RST) begin
			raw_sync_reg   <= 2'h3;
			rdy_sync_reg   <= 2'h3;
			strap_sync_reg <= 2'h0;
		end else begin
			raw_sync_reg   <= {raw_sync_reg[0], RAW_READ_N};
			rdy_sync_reg   <= {rdy_sync_reg[0], DRIVE_READY_N};
			strap_sync_reg <= {strap_sync_reg[0], STRAP_JUMPER};
		end
	end

	// 2 MHz tick from the board clock
	assign tick = (div_reg == 6'(SEP_DIV - 1));
	always_ff @(posedge CLK) begin
		if (RST)
			div_reg <= 6'h00;
		else
			div_reg <= tick ? 6'h00 : div_reg + 6'h01;
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			raw_prev_reg <= 1'b1;
			nrz_reg      <= 1'b0;
		end else begin
			raw_prev_reg <= raw_sync_reg[1];
			if (raw_prev_reg && !raw_sync_reg[1])
				nrz_reg <= ~nrz_reg;
		end
	end

	// Level back to one pulse per tick
	assign sep_pulse = tick && (nrz_reg != nrz_tick_reg);
	always_ff @(posedge CLK) begin
		if (RST)
			nrz_tick_reg <= 1'b0;
		else if (tick)
			nrz_tick_reg <= nrz_reg;
	end

	always_comb begin
		cnt_next = cnt_reg;
		if (sep_pulse)
			cnt_next = {cnt_reg[SEP_MSB], SEP_LOAD_LOW};
		else if (tick)
			// Free count rolls over from 1111
			cnt_next = cnt_reg + 4'h1;
	end

	always_ff @(posedge CLK) begin
		if (RST)
			cnt_reg <= SEP_CNT_RST;
		else
			cnt_reg <= cnt_next;
	end

	// Phase steers pulse; held until buffer takes it or the next pulse overwrites it
	always_ff @(posedge CLK) begin
		if (RST) begin
			pend_reg      <= 1'b0;
			pend_word_reg <= '0;
		end else if (sep_pulse) begin
			pend_reg                <= 1'b1;
			pend_word_reg[W_CLOCK]  <= !cnt_reg[SEP_MSB];
			pend_word_reg[W_DATA]   <= cnt_reg[SEP_MSB];
		end else if (fill_if.ready) begin
			pend_reg <= 1'b0;
		end
	end

	assign fill_if.valid = pend_reg;
	assign fill_if.data  = pend_word_reg;

	fmsep_buf u_buf (
		.clk    (CLK),
		.rst    (RST),
		.in_if  (fill_if),
		.out_if (drain_if)
	);

	// One word per accepted beat gives a single leading edge
	assign drain_if.ready  = SEP_READY;
	assign SEP_VALID       = drain_if.valid;
	assign SEP_CLOCK_PULSE = drain_if.valid && drain_if.data[W_CLOCK];
	assign SEP_DATA_PULSE  = drain_if.valid && drain_if.data[W_DATA];

	always_ff @(posedge CLK) begin
		if (RST)
			dsel_cnt_reg <= 32'h0000_0000;
		else
			dsel_cnt_reg <= oneshot_next(CTRL_WR, dsel_cnt_reg, DSEL_CYCLES);
	end
	assign dsel_run = (dsel_cnt_reg != 32'h0000_0000);

	// Expiry clears selects, motor latch survives
	always_ff @(posedge CLK) begin
		if (RST) begin
			sel_reg       <= CTL_SEL_RST;
			strap_low_reg <= 1'b0;
			motor_reg     <= 1'b0;
		end else if (CTRL_WR) begin
			sel_reg       <= CTRL_DATA[3:0];
			strap_low_reg <= CTRL_DATA[CTL_STRAP_LOW];
			motor_reg     <= CTRL_DATA[CTL_MOTOR];
		end else if (!dsel_run) begin
			sel_reg       <= CTL_SEL_RST;
			strap_low_reg <= 1'b0;
		end
	end

	assign DRIVE_SELECT      = sel_reg;
	assign MOTOR_ON          = motor_reg;
	// Strap point high unless bit 6 latched
	assign STRAP_SENSE_POINT = !strap_low_reg;

	// Ready from drive line or strap, gated by one-shot
	assign drive_ok  = strap_sync_reg[1] ? STRAP_SENSE_POINT : !rdy_sync_reg[1];
	assign FMT_READY = dsel_run && drive_ok;

	always_ff @(posedge CLK) begin
		if (RST)
			STATUS_DATA <= STATUS_RST;
		else if (STATUS_RD)
			STATUS_DATA <= {!FMT_READY, STATUS_COND, DATA_REQUEST_FLAG, BUSY};
	end

	assign hld_rise = HEAD_LOAD_REQUEST && !hld_prev_reg;
	always_ff @(posedge CLK) begin
		if (RST) begin
			hld_prev_reg <= 1'b0;
			hset_cnt_reg <= 32'h0000_0000;
		end else begin
			hld_prev_reg <= HEAD_LOAD_REQUEST;
			hset_cnt_reg <= oneshot_next(hld_rise, hset_cnt_reg, HSET_CYCLES);
		end
	end
	assign HEAD_SETTLE_INPUT = (hset_cnt_reg == 32'h0000_0000);

	// No head-load request means immediate start
	assign XFER_GO = XFER_REQ && HEAD_SETTLE_INPUT && !hld_rise;

	a_status_notready: assert property (@(posedge CLK) disable iff (RST)
		STATUS_RD |=> STATUS_DATA[ST_NOT_READY] == !$past(FMT_READY))
		else $error("status not-ready bit wrong");
	a_status_busy: assert property (@(posedge CLK) disable iff (RST)
		STATUS_RD |=> STATUS_DATA[ST_BUSY] == $past(BUSY) && STATUS_DATA[ST_DRQ] == $past(DATA_REQUEST_FLAG))
		else $error("status busy or request bit wrong");
	a_ready_oneshot: assert property (@(posedge CLK) disable iff (RST)
		!dsel_run |-> !FMT_READY)
		else $error("ready without running one-shot");
	a_settle_hold: assert property (@(posedge CLK) disable iff (RST)
		hld_rise |=> !HEAD_SETTLE_INPUT [*8])
		else $error("head settle not held low");
	a_xfer_defer: assert property (@(posedge CLK) disable iff (RST)
		!HEAD_SETTLE_INPUT |-> !XFER_GO)
		else $error("transfer started during settle");
	a_load_phase: assert property (@(posedge CLK) disable iff (RST)
		sep_pulse |=> cnt_reg == {$past(cnt_reg[SEP_MSB]), SEP_LOAD_LOW})
		else $error("counter load value wrong");
	a_roll_toggle: assert property (@(posedge CLK) disable iff (RST)
		tick && !sep_pulse && cnt_reg == 4'hF |=> cnt_reg == 4'h0)
		else $error("counter overflow wrong");
	a_steer_word: assert property (@(posedge CLK) disable iff (RST)
		sep_pulse |=> pend_reg && pend_word_reg[W_DATA] == $past(cnt_reg[SEP_MSB])
			&& pend_word_reg[W_CLOCK] != pend_word_reg[W_DATA])
		else $error("pulse steered wrong");
	a_expiry_motor: assert property (@(posedge CLK) disable iff (RST)
		!dsel_run && !CTRL_WR |=> sel_reg == CTL_SEL_RST && motor_reg == $past(motor_reg))
		else $error("expiry handling wrong");
	a_reset_clear: assert property (@(posedge CLK)
		RST |=> cnt_reg == SEP_CNT_RST)
		else $error("reset left counter set");
endmodule : fmsep_top

/* tb/fmsep_drive_model.sv */
`timescale 1ns/1ns
module fmsep_drive_model (
	// Clock and bench command
	input  wire logic clk,
	input  wire logic ready_cmd,
	// Drive pins, low true
	output logic      raw_read_n,
	output logic      drive_ready_n
);
	initial begin
		raw_read_n    = 1'b1;
		drive_ready_n = 1'b1;
	end
	always @(negedge clk) begin
		drive_ready_n <= ~ready_cmd;
	end
	// Gap counted from falling edge to falling edge, in 50-cycle ticks
	task automatic pulse_after(input int ticks);
		repeat (ticks * 50 - 20) @(negedge clk);
		raw_read_n <= 1'b0;
		repeat (20) @(negedge clk);
		raw_read_n <= 1'b1;
	endtask : pulse_after
endmodule : fmsep_drive_model

/* tb/test_fm_data_separator_head_load.sv */
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module test_fm_data_separator_head_load;
	import fmsep_pkg::*;
	localparam int unsigned DSEL_N = 200;
	localparam int unsigned HSET_N = 50;
	logic       clk, rst, ready_cmd, raw_n, rdy_n, jumper, ctrl_wr, status_rd, busy, data_request_flag;
	logic       hlr, xfer_req, sep_ready, motor, strap, fmt_ready, settle, xfer_go, valid, cpul, dpul;
	logic [7:0] ctrl_data, status;
	logic [4:0] cond;
	logic [3:0] sel;
	logic       got_q[$];
	int         num_errors = 0;
	int         n_checks   = 0;

	fmsep_drive_model drv (.clk(clk), .ready_cmd(ready_cmd), .raw_read_n(raw_n), .drive_ready_n(rdy_n));
	fmsep_top #(.DSEL_CYCLES(DSEL_N), .HSET_CYCLES(HSET_N)) dut (
		.CLK(clk), .RST(rst), .RAW_READ_N(raw_n), .DRIVE_READY_N(rdy_n), .STRAP_JUMPER(jumper),
		.DRIVE_SELECT(sel), .MOTOR_ON(motor), .STRAP_SENSE_POINT(strap), .CTRL_WR(ctrl_wr),
		.CTRL_DATA(ctrl_data), .STATUS_RD(status_rd), .BUSY(busy), .DATA_REQUEST_FLAG(data_request_flag),
		.STATUS_COND(cond), .STATUS_DATA(status), .FMT_READY(fmt_ready), .HEAD_LOAD_REQUEST(hlr),
		.XFER_REQ(xfer_req), .HEAD_SETTLE_INPUT(settle), .XFER_GO(xfer_go), .SEP_READY(sep_ready),
		.SEP_VALID(valid), .SEP_CLOCK_PULSE(cpul), .SEP_DATA_PULSE(dpul));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Separated words taken at the handshake
	always @(posedge clk) begin
		if (valid === 1'b1 && sep_ready === 1'b1) begin
			got_q.push_back(cpul);
			`CHK("one_pulse_kind", 1'b1, cpul ^ dpul)
		end
	end

	task automatic cycles(input int n);
		repeat (n) @(negedge clk);
	endtask : cycles
	task automatic ctl_write(input logic [7:0] d);
		ctrl_data = d;
		ctrl_wr = 1'b1;
		cycles(1);
		ctrl_wr = 1'b0;
		cycles(1);
	endtask : ctl_write
	task automatic status_read(input logic [7:0] e);
		status_rd = 1'b1;
		cycles(1);
		status_rd = 1'b0;
		cycles(1);
		`CHK("status", e, status)
	endtask : status_read

	task automatic t_reset();
		`CHK("sel_rst", 4'h0, sel)
		`CHK("motor_rst", 1'b0, motor)
		`CHK("valid_rst", 1'b0, valid)
		`CHK("settle_rst", 1'b1, settle)
		`CHK("ready_rst", 1'b0, fmt_ready)
	endtask : t_reset
	task automatic t_status();
		{busy, data_request_flag, cond} = {1'b1, 1'b0, 5'h0A};
		status_read(8'hA9);
		{busy, data_request_flag, cond} = {1'b0, 1'b1, 5'h15};
		status_read(8'hD6);
	endtask : t_status
	task automatic t_strap();
		jumper = 1'b1;
		ctl_write(8'h10);
		`CHK("strap_hi", 1'b1, strap)
		`CHK("motor_on", 1'b1, motor)
		`CHK("no_sel", 4'h0, sel)
		`CHK("rdy_strap", 1'b1, fmt_ready)
		status_read(8'h56);
		ctl_write(8'h42);
		`CHK("sel_two", 4'h2, sel)
		`CHK("strap_lo", 1'b0, strap)
		`CHK("rdy_lo", 1'b0, fmt_ready)
		jumper = 1'b0;
		ready_cmd = 1'b1;
		cycles(5);
		`CHK("rdy_drive", 1'b1, fmt_ready)
	endtask : t_strap
	task automatic t_expiry();
		ctl_write(8'h51);
		cycles(DSEL_N - 50);
		ctl_write(8'h51);
		cycles(DSEL_N - 20);
		`CHK("sel_kept", 4'h1, sel)
		cycles(40);
		`CHK("sel_clr", 4'h0, sel)
		`CHK("motor_kept", 1'b1, motor)
		`CHK("rdy_expired", 1'b0, fmt_ready)
	endtask : t_expiry
	task automatic t_head();
		int n;
		n = 0;
		xfer_req = 1'b1;
		cycles(2);
		`CHK("go_now", 1'b1, xfer_go)
		hlr = 1'b1;
		cycles(1);
		`CHK("go_held", 1'b0, xfer_go)
		while (settle === 1'b0 && n < 200) begin
			n++;
			cycles(1);
		end
		`CHK("settle_len", HSET_N, n)
		`CHK("go_after", 1'b1, xfer_go)
		{hlr, xfer_req} = 2'b00;
	endtask : t_head
	task automatic t_sep();
		int n;
		logic [4:0] exp_w;
		n = 0;
		// Counter has run ten ticks since reset, so phase is high at the first pulse
		exp_w = 5'b01001;
		sep_ready = 1'b0;
		fork
			begin
				drv.pulse_after(2);
				drv.pulse_after(8);
				drv.pulse_after(8);
				drv.pulse_after(14);
				drv.pulse_after(7);
			end
			begin
				cycles(1100);
				`CHK("stall_valid", 1'b1, valid)
				sep_ready = 1'b1;
			end
		join
		while (got_q.size() < 5 && n < 500) begin
			n++;
			cycles(1);
		end
		`CHK("word_count", 5, got_q.size())
		for (int i = 0; i < 5 && i < got_q.size(); i++) begin
			`CHK("steer", exp_w[4 - i], got_q[i])
		end
	endtask : t_sep

	task automatic final_report();
		if (num_errors == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : final_report

	initial begin
		#100_000;
		num_errors++;
		final_report();
	end
	initial begin
		{rst, ready_cmd, jumper, ctrl_wr, status_rd, busy, data_request_flag, hlr, xfer_req} = 9'h100;
		{ctrl_data, cond, sep_ready} = {8'h00, 5'h00, 1'b1};
		cycles(6);
		rst = 1'b0;
		t_reset();
		t_status();
		t_strap();
		t_expiry();
		t_head();
		t_sep();
		final_report();
	end
endmodule : test_fm_data_separator_head_load
